// ### nvs_defines.vh
// Timing counts, command codes and widths for the nonvolatile SRAM host controller.
// Assumes a 200 MHz controller clock; every count is derived from its time.
`ifndef NVS_DEFINES_VH
`define NVS_DEFINES_VH

`define NVS_CLK_PERIOD_NS 5
`define NVS_SYNC_STAGES 2

// Access timing, slowest speed grade
`define NVS_SEQ_READ_NS 45
`define NVS_SEQ_READ_CYC ((`NVS_SEQ_READ_NS + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS)
`define NVS_PIN_PULSE_NS 15
`define NVS_PIN_PULSE_CYC ((`NVS_PIN_PULSE_NS + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS)
`define NVS_BUSY_LAT_NS 500
`define NVS_BUSY_LAT_CYC (`NVS_BUSY_LAT_NS / `NVS_CLK_PERIOD_NS)
`define NVS_BUSY_HIGH_NS 500

// Long times in microseconds and milliseconds
`define NVS_SETTLE_US 100
`define NVS_SETTLE_CYC (`NVS_SETTLE_US * 1000 / `NVS_CLK_PERIOD_NS)
`define NVS_PU_HOLD_US 70
`define NVS_PU_HOLD_CYC ((`NVS_PU_HOLD_US * 1000 + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS)
`define NVS_BUSY_OUT_US 5
`define NVS_BUSY_OUT_CYC ((`NVS_BUSY_OUT_US * 1000 + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS)
`define NVS_GRACE_MAX_US 70
`define NVS_STORE_MS 8
`define NVS_STORE_CYC (`NVS_STORE_MS * 1000000 / `NVS_CLK_PERIOD_NS)
`define NVS_PU_RESTORE_MS 20
`define NVS_PU_RESTORE_CYC (`NVS_PU_RESTORE_MS * 1000000 / `NVS_CLK_PERIOD_NS)
`define NVS_SOFT_RESTORE_US 200
`define NVS_SOFT_RESTORE_CYC (`NVS_SOFT_RESTORE_US * 1000 / `NVS_CLK_PERIOD_NS)

// Command codes on cmd_op_in
`define NVS_OP_PIN_SAVE 3'h0
`define NVS_OP_SOFT_SAVE 3'h1
`define NVS_OP_SOFT_RESTORE 3'h2
`define NVS_OP_AUTO_ENABLE 3'h3
`define NVS_OP_AUTO_DISABLE 3'h4

`define NVS_CNT_W 23
`define NVS_SEQ_LEN 6

`endif

// ### nvs_sync.v
// Two-stage synchroniser for pins that arrive from the asynchronous memory.
// Assumes the input is a level that stays put for several clocks.
`timescale 1ns/1ps
module nvs_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire mclk_in,
   input wire rst_b_in,
   input wire [W-1:0] d_in,
   output reg [W-1:0] q_out
);
   reg [W-1:0] meta;

   // First stage feeds the second only
   always @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta <= INIT;
         q_out <= INIT;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule

// ### nvs_host.v
// Host controller driving an asynchronous nonvolatile SRAM through its pins.
// Assumes a supply supervisor gives pwr_ok_in; all pin inputs are synchronised here.
`timescale 1ns/1ps
`include "nvs_defines.vh"

// Summary of operation
// - Busy pin released during ordinary accesses
// - Pin save pulse low at least 15 ns
// - Six reads of table, write strobe high
// - Sequence reads timed by chip select
// - No access during settle after sixth read
module nvs_host #(
   parameter AW = 18,
   parameter DW = 16,
   // unlock tables, entry 0 in the low bits
   parameter [6*AW-1:0] SAVE_SEQ = {6*AW{1'b0}},
   parameter [6*AW-1:0] RESTORE_SEQ = {6*AW{1'b0}},
   parameter [6*AW-1:0] AUTO_EN_SEQ = {6*AW{1'b0}},
   parameter [6*AW-1:0] AUTO_DIS_SEQ = {6*AW{1'b0}},
   parameter [`NVS_CNT_W-1:0] ACC_CYC = `NVS_SEQ_READ_CYC,
   parameter [`NVS_CNT_W-1:0] PULSE_CYC = `NVS_PIN_PULSE_CYC,
   parameter [`NVS_CNT_W-1:0] LAT_CYC = `NVS_BUSY_LAT_CYC,
   parameter [`NVS_CNT_W-1:0] SETTLE_CYC = `NVS_SETTLE_CYC,
   parameter [`NVS_CNT_W-1:0] PU_HOLD_CYC = `NVS_PU_HOLD_CYC,
   parameter [`NVS_CNT_W-1:0] BUSY_OUT_CYC = `NVS_BUSY_OUT_CYC,
   parameter [`NVS_CNT_W-1:0] STORE_CYC = `NVS_STORE_CYC,
   parameter [`NVS_CNT_W-1:0] PU_RESTORE_CYC = `NVS_PU_RESTORE_CYC,
   parameter [`NVS_CNT_W-1:0] SOFT_RESTORE_CYC = `NVS_SOFT_RESTORE_CYC
) (
   input wire mclk_in,
   input wire rst_b_in,
   input wire pwr_ok_in,
   input wire acc_valid_in,
   input wire acc_write_in,
   input wire [AW-1:0] acc_addr_in,
   input wire [DW-1:0] acc_wdata_in,
   input wire [1:0] acc_be_in,
   input wire cmd_valid_in,
   input wire [2:0] cmd_op_in,
   output reg ready_out,
   output reg acc_done_out,
   output reg [DW-1:0] acc_rdata_out,
   output reg cmd_done_out,
   output reg timeout_out,
   output reg dirty_out,
   output reg [AW-1:0] addr_out,
   output reg chip_select_n_out,
   output reg write_strobe_n_out,
   output reg output_gate_n_out,
   output reg upper_byte_lane_n_out,
   output reg lower_byte_lane_n_out,
   output reg [DW-1:0] data_out,
   output reg data_oe_out,
   input wire [DW-1:0] data_in,
   output reg store_request_busy_n_out,
   output reg store_request_busy_n_oe_out,
   input wire store_request_busy_n_in
);
   localparam ST_BOOT = 12'h001;
   localparam ST_IDLE = 12'h002;
   localparam ST_RD = 12'h004;
   localparam ST_WR = 12'h008;
   localparam ST_GAP = 12'h010;
   localparam ST_SEQ = 12'h020;
   localparam ST_SEQ_GAP = 12'h040;
   localparam ST_SETTLE = 12'h080;
   localparam ST_PULSE = 12'h100;
   localparam ST_LAT = 12'h200;
   localparam ST_WAIT = 12'h400;
   localparam ST_RECOVER = 12'h800;

   reg [11:0] state;
   reg [`NVS_CNT_W-1:0] cnt;
   reg [`NVS_CNT_W-1:0] tmo;
   reg [2:0] op;
   reg [2:0] seq_idx;
   reg clear_dirty;
   wire busy_n_s;
   wire pwr_s;
   wire [DW-1:0] data_s;
   localparam [`NVS_CNT_W-1:0] sync_lag = `NVS_SYNC_STAGES;

   nvs_sync #(.W(2), .INIT(2'h0)) u_sync_ctl (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .d_in({store_request_busy_n_in, pwr_ok_in}),
      .q_out({busy_n_s, pwr_s})
   );

   nvs_sync #(.W(DW), .INIT({DW{1'b0}})) u_sync_data (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .d_in(data_in),
      .q_out(data_s)
   );

   // pick one unlock address for the running command
   function [AW-1:0] seq_addr;
      input [2:0] f_op;
      input [2:0] f_idx;
      reg [6*AW-1:0] tab;
      begin
         if (f_op == `NVS_OP_SOFT_SAVE) begin
            tab = SAVE_SEQ;
         end else if (f_op == `NVS_OP_SOFT_RESTORE) begin
            tab = RESTORE_SEQ;
         end else if (f_op == `NVS_OP_AUTO_ENABLE) begin
            tab = AUTO_EN_SEQ;
         end else begin
            tab = AUTO_DIS_SEQ;
         end
         seq_addr = tab[f_idx*AW +: AW];
      end
   endfunction

   // ----------------------------------------------------------------
   // Access and command sequencer
   // ----------------------------------------------------------------
   always @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= ST_BOOT;
         cnt <= {`NVS_CNT_W{1'b0}};
         tmo <= {`NVS_CNT_W{1'b0}};
         op <= 3'h0;
         seq_idx <= 3'h0;
         clear_dirty <= 1'b0;
         ready_out <= 1'b0;
         acc_done_out <= 1'b0;
         acc_rdata_out <= {DW{1'b0}};
         cmd_done_out <= 1'b0;
         timeout_out <= 1'b0;
         dirty_out <= 1'b0;
         addr_out <= {AW{1'b0}};
         chip_select_n_out <= 1'b1;
         write_strobe_n_out <= 1'b1;
         output_gate_n_out <= 1'b1;
         upper_byte_lane_n_out <= 1'b1;
         lower_byte_lane_n_out <= 1'b1;
         data_out <= {DW{1'b0}};
         data_oe_out <= 1'b0;
         store_request_busy_n_out <= 1'b0;
         store_request_busy_n_oe_out <= 1'b0;
      end else begin
         acc_done_out <= 1'b0;
         cmd_done_out <= 1'b0;
         ready_out <= 1'b0;
         store_request_busy_n_out <= 1'b0;
         cnt <= cnt + 1'b1;
         case (state)
            ST_BOOT: begin
               // count from supply rise, then wait for busy to end
               if (!pwr_s) begin
                  cnt <= {`NVS_CNT_W{1'b0}};
               end else if (cnt >= PU_HOLD_CYC) begin
                  tmo <= PU_RESTORE_CYC;
                  clear_dirty <= 1'b1;
                  cnt <= {`NVS_CNT_W{1'b0}};
                  state <= ST_WAIT;
               end
            end
            ST_IDLE: begin
               cnt <= {`NVS_CNT_W{1'b0}};
               // supply loss means an automatic save is under way when written and enabled
               if (!pwr_s || !busy_n_s) begin
                  state <= pwr_s ? ST_WAIT : ST_BOOT;
                  tmo <= STORE_CYC;
                  clear_dirty <= 1'b0;
               end else if (cmd_valid_in) begin
                  op <= cmd_op_in;
                  seq_idx <= 3'h0;
                  if (cmd_op_in == `NVS_OP_PIN_SAVE) begin
                     // drive the busy pin low only for the request
                     store_request_busy_n_oe_out <= 1'b1;
                     state <= ST_PULSE;
                  end else begin
                     // first sequence read, write strobe high
                     addr_out <= seq_addr(cmd_op_in, 3'h0);
                     chip_select_n_out <= 1'b0;
                     output_gate_n_out <= 1'b0;
                     upper_byte_lane_n_out <= 1'b0;
                     lower_byte_lane_n_out <= 1'b0;
                     state <= ST_SEQ;
                  end
               end else if (acc_valid_in) begin
                  // chip select plus strobes and lanes
                  addr_out <= acc_addr_in;
                  chip_select_n_out <= 1'b0;
                  upper_byte_lane_n_out <= ~acc_be_in[1];
                  lower_byte_lane_n_out <= ~acc_be_in[0];
                  if (acc_write_in) begin
                     write_strobe_n_out <= 1'b0;
                     data_out <= acc_wdata_in;
                     data_oe_out <= 1'b1;
                     state <= ST_WR;
                  end else begin
                     output_gate_n_out <= 1'b0;
                     state <= ST_RD;
                  end
               end else begin
                  ready_out <= 1'b1;
               end
            end
            ST_RD: begin
               // Synchroniser lag added before the data is taken
               if (cnt == ACC_CYC + sync_lag - 1'b1) begin
                  acc_rdata_out <= data_s;
                  acc_done_out <= 1'b1;
                  chip_select_n_out <= 1'b1;
                  output_gate_n_out <= 1'b1;
                  state <= ST_GAP;
               end
            end
            ST_WR: begin
               if (cnt == ACC_CYC - 1'b1) begin
                  write_strobe_n_out <= 1'b1;
                  chip_select_n_out <= 1'b1;
                  acc_done_out <= 1'b1;
                  // a finished write marks the array dirty
                  dirty_out <= 1'b1;
                  state <= ST_GAP;
               end
            end
            ST_GAP: begin
               // Select is high here so the address may change safely
               data_oe_out <= 1'b0;
               upper_byte_lane_n_out <= 1'b1;
               lower_byte_lane_n_out <= 1'b1;
               state <= ST_IDLE;
            end
            ST_SEQ: begin
               if (cnt == ACC_CYC - 1'b1) begin
                  // end each read with chip select high
                  chip_select_n_out <= 1'b1;
                  output_gate_n_out <= 1'b1;
                  cnt <= {`NVS_CNT_W{1'b0}};
                  state <= ST_SEQ_GAP;
               end
            end
            ST_SEQ_GAP: begin
               cnt <= {`NVS_CNT_W{1'b0}};
               // nothing but the table is issued, so order holds
               if (seq_idx == `NVS_SEQ_LEN - 1) begin
                  upper_byte_lane_n_out <= 1'b1;
                  lower_byte_lane_n_out <= 1'b1;
                  state <= ST_SETTLE;
               end else begin
                  seq_idx <= seq_idx + 1'b1;
                  addr_out <= seq_addr(op, seq_idx + 1'b1);
                  chip_select_n_out <= 1'b0;
                  output_gate_n_out <= 1'b0;
                  state <= ST_SEQ;
               end
            end
            ST_SETTLE: begin
               // hold the bus idle for the whole settle time
               if (cnt == SETTLE_CYC - 1'b1) begin
                  cnt <= {`NVS_CNT_W{1'b0}};
                  // data stays blocked until busy goes away
                  tmo <= (op == `NVS_OP_SOFT_RESTORE) ? SOFT_RESTORE_CYC : STORE_CYC;
                  clear_dirty <= (op == `NVS_OP_SOFT_SAVE) || (op == `NVS_OP_SOFT_RESTORE);
                  state <= ST_WAIT;
               end
            end
            ST_PULSE: begin
               if (cnt == PULSE_CYC - 1'b1) begin
                  store_request_busy_n_oe_out <= 1'b0;
                  cnt <= {`NVS_CNT_W{1'b0}};
                  state <= ST_LAT;
               end
            end
            ST_LAT: begin
               // busy may not come at all when nothing was written
               if (cnt == LAT_CYC + sync_lag - 1'b1) begin
                  cnt <= {`NVS_CNT_W{1'b0}};
                  tmo <= STORE_CYC;
                  clear_dirty <= 1'b1;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // released pin reads high once busy ends
               if (busy_n_s || cnt == tmo) begin
                  timeout_out <= !busy_n_s;
                  if (clear_dirty) begin
                     // completed save or restore clears the flag
                     dirty_out <= 1'b0;
                  end
                  cnt <= {`NVS_CNT_W{1'b0}};
                  state <= ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               // outputs need time to come back
               if (!busy_n_s) begin
                  cnt <= {`NVS_CNT_W{1'b0}};
               end else if (cnt == BUSY_OUT_CYC - 1'b1) begin
                  cmd_done_out <= (op != 3'h7);
                  clear_dirty <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_BOOT;
            end
         endcase
      end
   end
endmodule

// ### nvs_host_properties.sv
// Pin-side checks for the nonvolatile SRAM host controller.
// Assumes default access and pulse counts: 9-cycle access count, 3-cycle store pulse.
`timescale 1ns/1ps
module nvs_host_props (
   input wire mclk_in,
   input wire rst_b_in,
   input wire acc_done_out,
   input wire dirty_out,
   input wire cmd_done_out,
   input wire chip_select_n_out,
   input wire write_strobe_n_out,
   input wire output_gate_n_out,
   input wire data_oe_out,
   input wire store_request_busy_n_out,
   input wire store_request_busy_n_oe_out
);
   // ----------------------------------------
   // Pin relations
   // ----------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_b_in);
   a_idle_strobes_high: assert property (chip_select_n_out |-> write_strobe_n_out && output_gate_n_out)
      else $error("strobe active while deselected");
   a_read_not_driven: assert property (!output_gate_n_out |-> !data_oe_out)
      else $error("bus driven during read");
   a_write_drives_bus: assert property (!write_strobe_n_out |-> data_oe_out && !chip_select_n_out)
      else $error("write without data or select");
   a_busy_quiet_access: assert property (!chip_select_n_out |-> !store_request_busy_n_oe_out)
      else $error("busy pin pulled during access");
   a_store_pulse_width: assert property ($rose(store_request_busy_n_oe_out) |->
      store_request_busy_n_oe_out [*3] ##1 !store_request_busy_n_oe_out)
      else $error("store pulse not three cycles");
   a_read_cycle_length: assert property ($fell(chip_select_n_out) |-> ##1 !chip_select_n_out [*8])
      else $error("select shorter than cycle time");
   a_write_done_time: assert property ($fell(write_strobe_n_out) |-> ##9 acc_done_out)
      else $error("write done late or early");
   a_dirty_after_write: assert property ($rose(write_strobe_n_out) |-> dirty_out)
      else $error("dirty not set by write");
   a_busy_open_drain: assert property (store_request_busy_n_out == 1'b0)
      else $error("busy pin driven high");
   cover property ($rose(store_request_busy_n_oe_out));
   cover property (cmd_done_out && !dirty_out);
   cover property (acc_done_out && write_strobe_n_out);
endmodule

// ### nvs_mem_model.sv
// Behavioural nonvolatile SRAM, eight words, seen from its pins.
// Assumes the bench resolves the data bus and the pulled-up busy pin.
`timescale 1ns/1ps
module nvs_mem_model #(
   parameter AW = 18,
   parameter [24*AW-1:0] TBL = 0
) (
   input wire mclk_in,
   input wire pwr_ok_in,
   input wire [AW-1:0] addr_in,
   input wire cs_n_in,
   input wire we_n_in,
   input wire oe_n_in,
   input wire ub_n_in,
   input wire lb_n_in,
   input wire [15:0] bus_in,
   input wire busy_pin_in,
   output logic [15:0] drv_out,
   output logic busy_low_out
);
   // ----------------------------------------
   // Array, shadow copy and sequencing
   // ----------------------------------------
   logic [15:0] mem [0:7];
   logic [15:0] nv [0:7];
   logic [15:0] last = 16'h0000;
   logic [6*AW-1:0] hist = 0;
   logic [6*AW-1:0] nh;
   logic [2:0] a;
   logic dirty = 0, auto_en = 1, cs_q = 1, pwr_q = 0, live, rd;
   int cnt = 0, dly = 0, pend = 0;
   // accesses ignored while busy or supply low
   assign live = cnt == 0 && pwr_ok_in;
   // busy released to the pull-up when done
   assign busy_low_out = cnt != 0;
   assign nh = {addr_in, hist[6*AW-1:AW]};
   assign a = addr_in[2:0];
   assign rd = live && !cs_n_in && we_n_in && !oe_n_in;
   // released lanes show the inverse, never a stale value
   always_comb begin
      drv_out = ~last;
      if (rd && !lb_n_in) drv_out[7:0] = mem[a][7:0];
      if (rd && !ub_n_in) drv_out[15:8] = mem[a][15:8];
   end
   task automatic copy(input bit save, input int busy);
      for (int i = 0; i < 8; i++) begin
         if (save) nv[i] <= mem[i];
         else mem[i] <= nv[i];
      end
      dirty <= 0;
      cnt <= busy;
   endtask
   initial for (int i = 0; i < 8; i++) begin
      mem[i] = 16'h0000;
      nv[i] = 16'h0000;
   end
   always @(posedge mclk_in) begin
      last <= bus_in;
      cs_q <= cs_n_in;
      pwr_q <= pwr_ok_in;
      if (cnt > 0) cnt <= cnt - 1;
      if (dly > 0) dly <= dly - 1;
      if (pwr_ok_in && !pwr_q) copy(0, 30);
      // save on supply fall only if written and enabled
      else if (!pwr_ok_in && pwr_q && dirty && auto_en) copy(1, 40);
      // pin request answered next cycle when written
      else if (live && !busy_pin_in && dirty) copy(1, 40);
      // soft command acted on six cycles after the sixth select falls, before that read ends
      else if (dly == 1 && pend < 2) copy(pend == 0, pend == 0 ? 40 : 30);
      else if (dly == 1) auto_en <= pend == 2;
      // a real write marks the array and aborts a sequence
      if (live && !cs_n_in && !we_n_in && !(ub_n_in && lb_n_in)) begin
         if (!lb_n_in) mem[a][7:0] <= bus_in[7:0];
         if (!ub_n_in) mem[a][15:8] <= bus_in[15:8];
         dirty <= 1;
         hist <= 0;
      end else if (live && cs_q && !cs_n_in) begin
         hist <= nh;
         // six reads matching one table in order
         for (int k = 0; k < 4; k++) if (nh == TBL[k*6*AW +: 6*AW]) begin
            pend <= k;
            dly <= 5;
         end
      end
   end
endmodule

// ### tb_nvs_host.sv
// Self-checking bench: host controller against the behavioural memory.
// Assumes shortened long counts; expectations kept in a local image.
`timescale 1ns/1ps
`include "nvs_defines.vh"
module tb_nvs_host;
   // ----------------------------------------
   // Stimulus, image and checking
   // ----------------------------------------
   function automatic [24*18-1:0] mk_tbl();
      for (int i = 0; i < 24; i++) mk_tbl[i*18 +: 18] = 18'h00100 + 18'((i / 6) * 16 + i % 6);
   endfunction
   localparam [24*18-1:0] TBL = mk_tbl();
   logic mclk_in = 0, rst_b_in = 0, pwr_ok_in = 0, acc_valid_in = 0, acc_write_in = 0;
   logic cmd_valid_in = 0;
   logic [17:0] acc_addr_in = 0;
   logic [15:0] acc_wdata_in = 0;
   logic [1:0] acc_be_in = 0;
   logic [2:0] cmd_op_in = 0;
   wire ready_out, acc_done_out, cmd_done_out, timeout_out, dirty_out, data_oe_out;
   wire chip_select_n_out, write_strobe_n_out, output_gate_n_out;
   wire upper_byte_lane_n_out, lower_byte_lane_n_out, busy_low, busy_w;
   wire store_request_busy_n_out, store_request_busy_n_oe_out;
   wire [15:0] acc_rdata_out, data_out, mdl_drv, bus;
   wire [17:0] addr_out;
   int errors = 0, checks = 0;
   logic [16:0] q [$];
   logic [16:0] e;
   logic [15:0] exp_m [0:7];
   logic [15:0] exp_nv [0:7];
   assign bus = data_oe_out ? data_out : mdl_drv;
   // pull-up holds the busy pin high once released
   assign busy_w = (store_request_busy_n_oe_out ? store_request_busy_n_out : 1'b1) & ~busy_low;
   nvs_host #(.SAVE_SEQ(TBL[107:0]), .RESTORE_SEQ(TBL[215:108]), .AUTO_EN_SEQ(TBL[323:216]),
      .AUTO_DIS_SEQ(TBL[431:324]), .SETTLE_CYC(23'h000014), .PU_HOLD_CYC(23'h00000A),
      .STORE_CYC(23'h0000C8), .PU_RESTORE_CYC(23'h00012C),
      .SOFT_RESTORE_CYC(23'h000064)) u_nvs_host (.mclk_in, .rst_b_in, .pwr_ok_in,
      .acc_valid_in, .acc_write_in, .acc_addr_in, .acc_wdata_in, .acc_be_in, .cmd_valid_in,
      .cmd_op_in, .ready_out, .acc_done_out, .acc_rdata_out, .cmd_done_out, .timeout_out,
      .dirty_out, .addr_out, .chip_select_n_out, .write_strobe_n_out, .output_gate_n_out,
      .upper_byte_lane_n_out, .lower_byte_lane_n_out, .data_out, .data_oe_out, .data_in(bus),
      .store_request_busy_n_out, .store_request_busy_n_oe_out, .store_request_busy_n_in(busy_w));
   nvs_mem_model #(.TBL(TBL)) u_nvs_mem_model (.mclk_in, .pwr_ok_in, .addr_in(addr_out),
      .cs_n_in(chip_select_n_out), .we_n_in(write_strobe_n_out), .oe_n_in(output_gate_n_out),
      .ub_n_in(upper_byte_lane_n_out), .lb_n_in(lower_byte_lane_n_out), .bus_in(bus),
      .busy_pin_in(busy_w), .drv_out(mdl_drv), .busy_low_out(busy_low));
   initial forever #2.5 mclk_in = ~mclk_in;
   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      checks++;
      if (seen !== expv) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_for(input int w);
      int i;
      for (i = 0; i < 4000; i++) begin
         @(negedge mclk_in);
         if ((w == 0 ? ready_out : w == 1 ? acc_done_out : cmd_done_out) === 1'b1) break;
      end
      if (i == 4000) begin
         errors++;
         finish_test();
      end
   endtask
   task automatic acc(input bit wr, input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
      wait_for(0);
      @(posedge mclk_in);
      acc_valid_in <= 1'b1;
      acc_write_in <= wr;
      acc_addr_in <= {15'h0000, a};
      acc_wdata_in <= d;
      acc_be_in <= be;
      @(posedge mclk_in);
      acc_valid_in <= 1'b0;
      if (wr && be[0]) exp_m[a][7:0] = d[7:0];
      if (wr && be[1]) exp_m[a][15:8] = d[15:8];
      q.push_back({!wr, exp_m[a]});
      wait_for(1);
   endtask
   task automatic cmd(input logic [2:0] op);
      wait_for(0);
      @(posedge mclk_in);
      cmd_valid_in <= 1'b1;
      cmd_op_in <= op;
      @(posedge mclk_in);
      cmd_valid_in <= 1'b0;
      // no request until the command is done
      wait_for(2);
      check(16'(timeout_out), 16'h0000);
   endtask
   task automatic read_all();
      for (int i = 0; i < 8; i++) acc(1'b0, 3'(i), 16'h0000, 2'h3);
   endtask
   task automatic power_cycle();
      @(posedge mclk_in);
      pwr_ok_in <= 1'b0;
      repeat (30) @(negedge mclk_in);
      check(16'(ready_out), 16'h0000);
      @(posedge mclk_in);
      pwr_ok_in <= 1'b1;
      repeat (15) @(negedge mclk_in);
      check(16'(ready_out), 16'h0000);
   endtask
   always @(negedge mclk_in) if (acc_done_out === 1'b1) begin
      if (q.size() == 0) check(16'h0001, 16'h0000);
      else begin
         e = q.pop_front();
         if (e[16]) check(acc_rdata_out, e[15:0]);
      end
   end
   initial begin
      void'($urandom(32'h365B));
      for (int i = 0; i < 8; i++) exp_m[i] = 16'h0000;
      repeat (12) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      pwr_ok_in <= 1'b1;
      repeat (20) @(negedge mclk_in);
      check(16'(ready_out), 16'h0000);
      for (int i = 0; i < 16; i++) acc(1'b1, 3'($urandom_range(7)), 16'($urandom), 2'($urandom_range(3)));
      read_all();
      check(16'(dirty_out), 16'h0001);
      cmd(`NVS_OP_PIN_SAVE);
      check(16'(dirty_out), 16'h0000);
      for (int i = 0; i < 8; i++) exp_nv[i] = exp_m[i];
      acc(1'b1, 3'h2, 16'hA5C3, 2'h3);
      cmd(`NVS_OP_SOFT_RESTORE);
      for (int i = 0; i < 8; i++) exp_m[i] = exp_nv[i];
      read_all();
      acc(1'b1, 3'h5, 16'h1234, 2'h1);
      cmd(`NVS_OP_SOFT_SAVE);
      for (int i = 0; i < 8; i++) exp_nv[i] = exp_m[i];
      acc(1'b1, 3'h6, 16'h5A5A, 2'h2);
      cmd(`NVS_OP_AUTO_DISABLE);
      power_cycle();
      for (int i = 0; i < 8; i++) exp_m[i] = exp_nv[i];
      read_all();
      cmd(`NVS_OP_AUTO_ENABLE);
      acc(1'b1, 3'h7, 16'hC0DE, 2'h3);
      power_cycle();
      read_all();
      cmd(`NVS_OP_PIN_SAVE);
      finish_test();
   end
endmodule
bind nvs_host nvs_host_props u_nvs_host_props (.mclk_in, .rst_b_in, .acc_done_out, .dirty_out,
   .cmd_done_out, .chip_select_n_out, .write_strobe_n_out, .output_gate_n_out, .data_oe_out,
   .store_request_busy_n_out, .store_request_busy_n_oe_out);
